/* File: hw/rictl_pkg.sv */
// Purpose: constants and carriers for the reset and interrupt control block
// Assumes: ref_clk is the main oscillator, one clock per oscillator period
// Notes: register offsets are byte addresses on the Avalon-MM slave
//
// How it works
// - reset comes from pin, fetch trap, watchdog or clock fault
// - a fault reset holds the core reset for at most 24 periods
// - fault reset may glitch up to 24 periods at power-up; tolerated
// - pin must stay low three machine cycles before reset applies
// - on pin release, restart from the vector at the top word
// - fetch from special area or data buffer traps; RAM only if enabled
// - trap gives reset or interrupt by select bit; areas selectable
// - trap outcome select resets to one, meaning reset
// - bad oscillator enable writes give a clock reset, oscillators kept; the write is dropped, then the reset reloads SYS_RESET
// - twenty sources, four non-maskable, rest maskable
// - nesting allowed; simultaneous requests taken by fixed priority
// - non-maskable sources share one level; reset alone is top
// - a pending latch sets on request and holds until accepted
// - maskable needs master and own enable; source 4 also pin enable
// - software and illegal opcode share a vector; latches 2,3 own
// - latches 4-15 and 16-19 map to descending vectors, low wins
// - acceptance takes eight machine cycles after instruction end
// - acceptance clears master enable and latch; stack takes three
// - reset clears the master enable
// - reset clears every pending latch

`default_nettype none

package rictl_pkg;

	// ********************************************************
	// register map
	// ********************************************************
	localparam logic [4:0] ADDR_CTRL = 5'h00;
	localparam logic [4:0] ADDR_SYSCTL = 5'h04;
	localparam logic [4:0] ADDR_ENABLE = 5'h08;
	localparam logic [4:0] ADDR_PENDING = 5'h0c;
	localparam logic [4:0] ADDR_STATUS = 5'h10;

	localparam int CTRL_MIE = 0;
	localparam int CTRL_RAMTRAP = 1;
	localparam int CTRL_TRAPOUT = 2;
	localparam int CTRL_EXT0EN = 3;
	localparam int CTRL_SPECTRAP = 4;
	localparam int CTRL_DBUFTRAP = 5;
	localparam int CTRL_W = 6;
	localparam logic [5:0] CTRL_RESET = 6'h34;

	localparam int SYS_CLKSEL = 0;
	localparam int SYS_LOEN = 1;
	localparam int SYS_HIEN = 2;
	localparam int SYS_W = 3;
	localparam logic [2:0] SYS_RESET = 3'h4;

	localparam int ST_CAUSE_W = 4;
	localparam int ST_BUSY = 4;
	localparam int ST_VEC_LSB = 16;

	// ********************************************************
	// sources and vectors
	// ********************************************************
	localparam int NUM_LAT = 20;
	localparam int LAT_TRAP = 2;
	localparam int LAT_WDT = 3;
	localparam int LAT_EXT0 = 4;
	localparam int LAT_HIGH = 16;
	localparam logic [15:0] VEC_RESET = 16'hfffe;
	localparam logic [15:0] VEC_SWI = 16'hfffc;
	localparam logic [15:0] VEC_TRAP = 16'hfffa;
	localparam logic [15:0] VEC_WDT = 16'hfff8;
	localparam logic [15:0] VEC_LOW_BASE = 16'hfff6;
	localparam logic [15:0] VEC_HIGH_BASE = 16'hffbe;

	// trapped fetch areas
	localparam logic [15:0] SPEC_LO = 16'h0000;
	localparam logic [15:0] SPEC_HI = 16'h003f;
	localparam logic [15:0] RAM_LO = 16'h0040;
	localparam logic [15:0] RAM_HI = 16'h083f;
	localparam logic [15:0] DBUF_LO = 16'h0f80;
	localparam logic [15:0] DBUF_HI = 16'h0fff;

	// ********************************************************
	// timing, in oscillator periods and machine cycles
	// ********************************************************
	localparam int CLK_PER_OSC = 1;
	localparam int OSC_PER_MC = 4;
	localparam int PIN_MIN_MC = 3;
	localparam int MAL_RST_OSC = 24;
	localparam int ACCEPT_MC = 8;
	localparam int PIN_MIN_CYC = PIN_MIN_MC * OSC_PER_MC * CLK_PER_OSC;
	localparam int MAL_RST_CYC = MAL_RST_OSC * CLK_PER_OSC;
	localparam int ACCEPT_CYC = ACCEPT_MC * OSC_PER_MC * CLK_PER_OSC;

	typedef enum logic [1:0] {
		ACC_IDLE = 2'b01,
		ACC_SEQ = 2'b10
	} rictl_acc_e;

	// ********************************************************
	// carriers towards the cpu core
	// ********************************************************
	typedef struct packed {
		logic insn_done;
		logic fetch_valid;
		logic [15:0] fetch_addr;
		logic swi_req;
		logic undef_req;
		logic reti;
		logic reti_mie;
	} rictl_cpu_in_s;

	typedef struct packed {
		logic core_rst;
		logic rst_release;
		logic irq_busy;
		logic irq_done;
		logic [15:0] vector;
		logic push_mie;
	} rictl_cpu_out_s;

endpackage : rictl_pkg

`default_nettype wire

/* File: hw/rictl_top.sv */
// Purpose: reset combining and interrupt priority for the cpu core
// Assumes: peripheral requests and cpu strobes are one-cycle pulses on
//   ref_clk; only the reset pin comes from outside the clock domain
// Notes: stack pushes are done by the core while irq_busy is high

`timescale 1ns/1ps
`default_nettype none

module rictl_top
	import rictl_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// avalon-mm slave
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// reset sources
	input wire logic rst_pin_n,
	input wire logic wdt_reset_req,
	// interrupt requests
	input wire logic wdt_irq_req,
	input wire logic [NUM_LAT-1:LAT_EXT0] periph_irq,
	// cpu core
	input wire rictl_cpu_in_s cpu_in,
	output rictl_cpu_out_s cpu_out
);

	// ********************************************************
	// helper functions
	// ********************************************************

	// byte enables widened into a bit mask
	function automatic logic [31:0] be_mask(input logic [3:0] be);
		logic [31:0] m;
		m = '0;
		for (int b = 0; b < 4; b++) begin
			m[b*8 +: 8] = {8{be[b]}};
		end
		return m;
	endfunction : be_mask

	// latch index to its vector
	function automatic logic [15:0] vec_of(input logic [4:0] idx);
		logic [15:0] off;
		off = '0;
		if (idx == 5'(LAT_TRAP)) begin
			vec_of = VEC_TRAP;
		end else if (idx == 5'(LAT_WDT)) begin
			vec_of = VEC_WDT;
		end else if (idx < 5'(LAT_HIGH)) begin
			off = 16'({idx - 5'(LAT_EXT0), 1'b0});
			vec_of = VEC_LOW_BASE - off;
		end else begin
			off = 16'({idx - 5'(LAT_HIGH), 1'b0});
			vec_of = VEC_HIGH_BASE - off;
		end
	endfunction : vec_of

	// lowest eligible index wins
	function automatic logic [4:0] pick(input logic [NUM_LAT-1:0] e);
		logic [4:0] r;
		r = '0;
		for (int i = NUM_LAT - 1; i >= LAT_TRAP; i--) begin
			if (e[i]) begin
				r = 5'(i);
			end
		end
		return r;
	endfunction : pick

	// ********************************************************
	// declarations
	// ********************************************************
	logic pin_s1_q, pin_s2_q;
	logic [4:0] pin_cnt_q;
	logic pin_rst_q;
	logic [4:0] mal_cnt_q;
	logic core_rst_d, core_rst_q, rel_q;
	logic [CTRL_W-1:0] ctrl_q;
	logic [SYS_W-1:0] sys_q;
	logic [NUM_LAT-1:0] en_q, pend_q, pend_d, set_v, elig;
	logic [ST_CAUSE_W-1:0] cause_q;
	rictl_acc_e acc_q;
	logic [5:0] acc_cnt_q;
	logic [15:0] vec_q;
	logic push_mie_q, done_q, ack_q;
	logic [31:0] rdata_q, wmask;
	logic wr_fire, wr_ctrl, wr_sys, wr_en, wr_pend, wr_stat;
	logic in_spec, in_dbuf, in_ram, trap_hit, trap_rst;
	logic hi_clr, lo_clr, sclk_rst, mal_req;
	logic nmi_sw, any_req, accept;
	logic [4:0] sel_idx;

	// ********************************************************
	// avalon-mm slave
	// ********************************************************

	// one wait state: data is prepared first, write lands on release
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
	assign wr_fire = avs_write & ack_q;
	assign wmask = be_mask(avs_byteenable);
	assign wr_ctrl = wr_fire & (avs_address == ADDR_CTRL);
	assign wr_sys = wr_fire & (avs_address == ADDR_SYSCTL);
	assign wr_en = wr_fire & (avs_address == ADDR_ENABLE);
	assign wr_pend = wr_fire & (avs_address == ADDR_PENDING);
	assign wr_stat = wr_fire & (avs_address == ADDR_STATUS);
	assign avs_readdata = rdata_q;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= (avs_read | avs_write) & ~ack_q;
		end
	end

	// read mux; unmapped offsets read as zero
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_q <= '0;
		end else begin
			case (avs_address)
				ADDR_CTRL: rdata_q <= 32'(ctrl_q);
				ADDR_SYSCTL: rdata_q <= 32'(sys_q);
				ADDR_ENABLE: rdata_q <= 32'(en_q);
				ADDR_PENDING: rdata_q <= 32'(pend_q);
				ADDR_STATUS: begin
					rdata_q <= {vec_q, 11'h000, acc_q == ACC_SEQ, cause_q};
				end
				default: rdata_q <= '0;
			endcase
		end
	end

	// ********************************************************
	// reset sources
	// ********************************************************

	// pin synchroniser
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			pin_s1_q <= 1'b1;
			pin_s2_q <= 1'b1;
		end else begin
			pin_s1_q <= rst_pin_n;
			pin_s2_q <= pin_s1_q;
		end
	end

	// short low pulses are filtered; reset holds until the pin rises
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			pin_cnt_q <= '0;
			pin_rst_q <= 1'b0;
		end else if (pin_s2_q) begin
			pin_cnt_q <= '0;
			pin_rst_q <= 1'b0;
		end else begin
			if (pin_cnt_q != 5'(PIN_MIN_CYC)) begin
				pin_cnt_q <= pin_cnt_q + 5'h01;
			end
			pin_rst_q <= pin_cnt_q >= 5'(PIN_MIN_CYC - 1);
		end
	end

	// fetch address areas
	assign in_spec = (cpu_in.fetch_addr >= SPEC_LO)
		& (cpu_in.fetch_addr <= SPEC_HI);
	assign in_ram = (cpu_in.fetch_addr >= RAM_LO)
		& (cpu_in.fetch_addr <= RAM_HI);
	assign in_dbuf = (cpu_in.fetch_addr >= DBUF_LO)
		& (cpu_in.fetch_addr <= DBUF_HI);
	assign trap_hit = cpu_in.fetch_valid & ~core_rst_q
		& ((in_spec & ctrl_q[CTRL_SPECTRAP])
		| (in_dbuf & ctrl_q[CTRL_DBUFTRAP])
		| (in_ram & ctrl_q[CTRL_RAMTRAP]));
	assign trap_rst = trap_hit & ctrl_q[CTRL_TRAPOUT];

	// an enable write that would stall the clock resets instead
	assign hi_clr = sys_q[SYS_HIEN] & wmask[SYS_HIEN]
		& ~avs_writedata[SYS_HIEN];
	assign lo_clr = sys_q[SYS_LOEN] & wmask[SYS_LOEN]
		& ~avs_writedata[SYS_LOEN];
	assign sclk_rst = wr_sys & ((hi_clr & lo_clr)
		| (hi_clr & ~sys_q[SYS_CLKSEL])
		| (lo_clr & sys_q[SYS_CLKSEL]));

	assign mal_req = trap_rst | wdt_reset_req | sclk_rst;

	// fault reset stretch; a counter glitch at power-up only adds a
	// short extra reset, which the core survives
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			mal_cnt_q <= '0;
		end else if (mal_req) begin
			mal_cnt_q <= 5'(MAL_RST_CYC);
		end else if (mal_cnt_q != 5'h00) begin
			mal_cnt_q <= mal_cnt_q - 5'h01;
		end
	end

	// single internal reset and release pulse
	assign core_rst_d = pin_rst_q | mal_req | (mal_cnt_q > 5'h01);
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			core_rst_q <= 1'b1;
			rel_q <= 1'b0;
		end else begin
			core_rst_q <= core_rst_d;
			rel_q <= core_rst_q & ~core_rst_d;
		end
	end

	// sticky causes: pin, trap, watchdog, clock; set beats clear
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cause_q <= '0;
		end else begin
			cause_q <= (cause_q & ~(wr_stat ? 4'(avs_writedata & wmask)
				: 4'h0)) | {sclk_rst, wdt_reset_req, trap_rst, pin_rst_q};
		end
	end

	// ********************************************************
	// control registers
	// ********************************************************

	// master enable: reset, then acceptance, then return, then software
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_q <= CTRL_RESET;
		end else if (core_rst_q) begin
			ctrl_q <= CTRL_RESET;
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= (ctrl_q & ~CTRL_W'(wmask))
					| (CTRL_W'(avs_writedata) & CTRL_W'(wmask));
			end
			if (accept) begin
				ctrl_q[CTRL_MIE] <= 1'b0;
			end else if (cpu_in.reti) begin
				ctrl_q[CTRL_MIE] <= cpu_in.reti_mie;
			end
		end
	end

	// oscillator and clock select; a faulting write is dropped
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			sys_q <= SYS_RESET;
		end else if (core_rst_q) begin
			sys_q <= SYS_RESET;
		end else if (wr_sys & ~sclk_rst) begin
			sys_q <= (sys_q & ~SYS_W'(wmask))
				| (SYS_W'(avs_writedata) & SYS_W'(wmask));
		end
	end

	// per-source enables exist only for maskable sources
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			en_q <= '0;
		end else if (core_rst_q) begin
			en_q <= '0;
		end else if (wr_en) begin
			en_q <= {(avs_writedata[NUM_LAT-1:LAT_EXT0]
				& wmask[NUM_LAT-1:LAT_EXT0]), 4'h0};
		end
	end

	// ********************************************************
	// pending latches
	// ********************************************************
	assign set_v = {periph_irq, wdt_irq_req,
		trap_hit & ~ctrl_q[CTRL_TRAPOUT], 2'b00};

	// software only clears (load of zero); a new request wins
	always_comb begin
		for (int i = 0; i < NUM_LAT; i++) begin
			pend_d[i] = pend_q[i];
			if (wr_pend & wmask[i] & ~avs_writedata[i]) begin
				pend_d[i] = 1'b0;
			end
			if (accept & ~nmi_sw & (sel_idx == 5'(i))) begin
				pend_d[i] = 1'b0;
			end
			if (set_v[i]) begin
				pend_d[i] = 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			pend_q <= '0;
		end else if (core_rst_q) begin
			pend_q <= '0;
		end else begin
			pend_q <= pend_d;
		end
	end

	// ********************************************************
	// priority and acceptance
	// ********************************************************
	generate
		for (genvar g = 0; g < NUM_LAT; g++) begin : g_elig
			if (g < LAT_TRAP) begin : g_none
				assign elig[g] = 1'b0;
			end else if (g < LAT_EXT0) begin : g_nmi
				assign elig[g] = pend_q[g];
			end else if (g == LAT_EXT0) begin : g_ext0
				assign elig[g] = pend_q[g] & en_q[g] & ctrl_q[CTRL_MIE]
					& ctrl_q[CTRL_EXT0EN];
			end else begin : g_mask
				assign elig[g] = pend_q[g] & en_q[g]
					& ctrl_q[CTRL_MIE];
			end
		end
	endgenerate

	// core-raised traps have no latch and share the top shared level
	assign nmi_sw = cpu_in.swi_req | cpu_in.undef_req;
	assign sel_idx = pick(elig);
	assign any_req = nmi_sw | (|elig);
	assign accept = (acc_q == ACC_IDLE) & cpu_in.insn_done & any_req
		& ~core_rst_q;

	// acceptance sequence: the core pushes three bytes meanwhile
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			acc_q <= ACC_IDLE;
			acc_cnt_q <= '0;
			done_q <= 1'b0;
		end else if (core_rst_q) begin
			acc_q <= ACC_IDLE;
			acc_cnt_q <= '0;
			done_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			case (acc_q)
				ACC_IDLE: begin
					if (accept) begin
						acc_q <= ACC_SEQ;
						acc_cnt_q <= 6'(ACCEPT_CYC - 1);
					end
				end
				ACC_SEQ: begin
					if (acc_cnt_q == 6'h00) begin
						acc_q <= ACC_IDLE;
						done_q <= 1'b1;
					end else begin
						acc_cnt_q <= acc_cnt_q - 6'h01;
					end
				end
				default: acc_q <= ACC_IDLE;
			endcase
		end
	end

	// vector and saved enable for the stacked status word
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			vec_q <= VEC_RESET;
			push_mie_q <= 1'b0;
		end else if (core_rst_q) begin
			vec_q <= VEC_RESET;
			push_mie_q <= 1'b0;
		end else if (accept) begin
			vec_q <= nmi_sw ? VEC_SWI : vec_of(sel_idx);
			push_mie_q <= ctrl_q[CTRL_MIE];
		end
	end

	// ********************************************************
	// outputs to the core
	// ********************************************************
	assign cpu_out.core_rst = core_rst_q;
	assign cpu_out.rst_release = rel_q;
	assign cpu_out.irq_busy = acc_q[1];
	assign cpu_out.irq_done = done_q;
	assign cpu_out.vector = vec_q;
	assign cpu_out.push_mie = push_mie_q;

endmodule : rictl_top

`default_nettype wire

/* File: bench/rictl_assertions.sv */
// Purpose: port checks on reset combining and interrupt acceptance
// Assumes: one clock domain, arst_n asynchronous and active low
// Notes: sees only top module ports; bound after the module

`timescale 1ns/1ps
`default_nettype none

module rictl_assertions
	import rictl_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// reset sources
	input wire logic rst_pin_n,
	input wire logic wdt_reset_req,
	// cpu core
	input wire rictl_cpu_in_s cpu_in,
	input wire rictl_cpu_out_s cpu_out
);
	// ********************************************************
	// helper counters
	// ********************************************************
	logic [4:0] pin_low_q;
	logic [5:0] rst_run_q;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);

	// pin low time, saturating so a long hold never wraps
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) pin_low_q <= 5'h00;
		else if (rst_pin_n) pin_low_q <= 5'h00;
		else if (pin_low_q != 5'h1f) pin_low_q <= pin_low_q + 5'h01;
	end

	// reset run since the last request; a new request restarts it
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) rst_run_q <= 6'h00;
		else if (!cpu_out.core_rst || !rst_pin_n) rst_run_q <= 6'h00;
		else if (wdt_reset_req || cpu_in.fetch_valid) rst_run_q <= 6'h00;
		else if (rst_run_q != 6'h3f) rst_run_q <= rst_run_q + 6'h01;
	end

	// ********************************************************
	// sequences and properties
	// ********************************************************
	sequence acc_run;
		cpu_out.irq_busy throughout ##30 1'b1;
	endsequence

	sequence mal_hold;
		cpu_out.core_rst throughout ##23 1'b1;
	endsequence

	accept_len_a: assert property ($rose(cpu_out.irq_busy) |->
		acc_run ##[1:2] (!cpu_out.irq_busy && cpu_out.irq_done))
		else $error("acceptance length wrong");
	accept_cause_a: assert property ($rose(cpu_out.irq_busy) |->
		$past(cpu_in.insn_done) && !cpu_out.core_rst)
		else $error("acceptance without instruction end");
	swi_vector_a: assert property (cpu_in.insn_done &&
		(cpu_in.swi_req || cpu_in.undef_req) && !cpu_out.irq_busy &&
		!cpu_out.irq_done && !cpu_out.core_rst |=>
		cpu_out.irq_busy && cpu_out.vector == VEC_SWI)
		else $error("software vector wrong");
	wdt_hold_a: assert property (wdt_reset_req |=> mal_hold)
		else $error("watchdog reset too short");
	mal_limit_a: assert property (rst_run_q <= 6'h18)
		else $error("malfunction reset too long");
	pin_apply_a: assert property (pin_low_q == 5'h14 |->
		cpu_out.core_rst)
		else $error("pin reset not applied");
	pin_release_a: assert property ($rose(rst_pin_n) &&
		cpu_out.core_rst |-> ##[1:8] cpu_out.rst_release)
		else $error("pin reset not released");
	release_vec_a: assert property (cpu_out.rst_release |->
		cpu_out.vector == VEC_RESET && $past(cpu_out.core_rst) &&
		!cpu_out.core_rst)
		else $error("reset release wrong");
	rst_quiet_a: assert property (cpu_out.core_rst &&
		$past(cpu_out.core_rst) |-> !cpu_out.irq_busy && !cpu_out.irq_done)
		else $error("acceptance during reset");
endmodule : rictl_assertions

bind rictl_top rictl_assertions u_chk (
	.ref_clk(ref_clk),
	.arst_n(arst_n),
	.rst_pin_n(rst_pin_n),
	.wdt_reset_req(wdt_reset_req),
	.cpu_in(cpu_in),
	.cpu_out(cpu_out)
);

`default_nettype wire

/* File: bench/rictl_cpu_model.sv */
// Purpose: behavioural cpu core facing the interrupt block
// Assumes: strobes change just after a rising edge
// Notes: stack is modelled only as a pointer

`timescale 1ns/1ps
`default_nettype none

module rictl_cpu_model
	import rictl_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// block side
	input wire rictl_cpu_out_s cpu_out,
	output rictl_cpu_in_s cpu_in
);
	logic [7:0] sp_q;
	logic [15:0] pc_q;
	logic busy_q;

	initial cpu_in = '0;

	// vector fetch and stack; the core pushes three bytes per entry
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			sp_q <= 8'hff;
			pc_q <= 16'h0000;
			busy_q <= 1'b0;
		end else begin
			busy_q <= cpu_out.irq_busy;
			if (cpu_out.rst_release) pc_q <= cpu_out.vector;
			if (cpu_out.irq_busy && !busy_q) sp_q <= sp_q - 8'h03;
			if (cpu_out.irq_busy && !busy_q) pc_q <= cpu_out.vector;
			if (cpu_in.reti) sp_q <= sp_q + 8'h03;
		end
	end

	// instruction end after gap idle cycles, slow or prompt
	task automatic step(input logic s, input logic u, input int gap);
		repeat (gap) @(posedge ref_clk);
		@(posedge ref_clk);
		cpu_in.insn_done <= 1'b1;
		cpu_in.swi_req <= s;
		cpu_in.undef_req <= u;
		@(posedge ref_clk);
		cpu_in.insn_done <= 1'b0;
		cpu_in.swi_req <= 1'b0;
		cpu_in.undef_req <= 1'b0;
	endtask : step

	// one fetch; address lines do not keep the last value afterwards
	task automatic fetch(input logic [15:0] a);
		@(posedge ref_clk);
		cpu_in.fetch_valid <= 1'b1;
		cpu_in.fetch_addr <= a;
		@(posedge ref_clk);
		cpu_in.fetch_valid <= 1'b0;
		cpu_in.fetch_addr <= ~a;
	endtask : fetch

	// return from a service routine, restoring the stacked enable
	task automatic ret(input logic mie);
		@(posedge ref_clk);
		cpu_in.reti <= 1'b1;
		cpu_in.reti_mie <= mie;
		@(posedge ref_clk);
		cpu_in.reti <= 1'b0;
		cpu_in.reti_mie <= ~mie;
	endtask : ret
endmodule : rictl_cpu_model

`default_nettype wire

/* File: bench/testbench.sv */
// Purpose: register and acceptance tests for the interrupt block
// Assumes: one wait state per bus access
// Notes: expected values come from the vector and priority table

`timescale 1ns/1ps
`default_nettype none

module testbench
	import rictl_pkg::*;
;
	logic ref_clk, arst_n, avs_read, avs_write, avs_waitrequest;
	logic [4:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	logic [3:0] avs_byteenable;
	logic rst_pin_n, wdt_reset_req, wdt_irq_req;
	logic [NUM_LAT-1:LAT_EXT0] periph_irq;
	rictl_cpu_in_s cpu_in;
	rictl_cpu_out_s cpu_out;
	int err_total, num_checks, cyc;

	// ********************************************************
	// clock, timeout and instances
	// ********************************************************
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	// ceiling more than ten times the cycles the tests need
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			test_done();
		end
	end

	rictl_top u_dut (.ref_clk(ref_clk), .arst_n(arst_n),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .rst_pin_n(rst_pin_n),
		.wdt_reset_req(wdt_reset_req), .wdt_irq_req(wdt_irq_req),
		.periph_irq(periph_irq), .cpu_in(cpu_in), .cpu_out(cpu_out));
	rictl_cpu_model u_cpu (.ref_clk(ref_clk), .arst_n(arst_n),
		.cpu_out(cpu_out), .cpu_in(cpu_in));

	// ********************************************************
	// tasks
	// ********************************************************
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// request held until waitrequest is sampled low at a rising edge
	task automatic bus(input logic rd, input logic [4:0] a,
		input logic [31:0] wd, output logic [31:0] q);
		@(posedge ref_clk);
		avs_address <= a;
		avs_writedata <= wd;
		avs_read <= rd;
		avs_write <= ~rd;
		do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b0, a, d, q);
	endtask : wr

	task automatic rd(input logic [4:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b1, a, 32'h0, q);
		chk($sformatf("reg %h", a), e, q);
	endtask : rd

	task automatic irq(input logic [15:0] m, input logic w);
		@(posedge ref_clk);
		periph_irq <= m;
		wdt_irq_req <= w;
		@(posedge ref_clk);
		periph_irq <= '0;
		wdt_irq_req <= 1'b0;
	endtask : irq

	// instruction end, then acceptance seen a cycle later or not at all
	task automatic take(input logic [15:0] ev, input logic eb,
		input logic s, input logic u);
		u_cpu.step(s, u, 0);
		@(negedge ref_clk);
		chk("irq_busy", {31'h0, eb}, {31'h0, cpu_out.irq_busy});
		if (eb) chk("vector", {16'h0, ev}, {16'h0, cpu_out.vector});
		for (int i = 0; i < 40 && cpu_out.irq_busy !== 1'b0; i++)
			@(negedge ref_clk);
		if (eb) chk("irq_done", 32'h1, {31'h0, cpu_out.irq_done});
	endtask : take

	task automatic wait_rst();
		repeat (4) @(posedge ref_clk);
		for (int i = 0; i < 60 && cpu_out.core_rst !== 1'b0; i++)
			@(posedge ref_clk);
		chk("core_rst", 32'h0, {31'h0, cpu_out.core_rst});
		@(posedge ref_clk);
	endtask : wait_rst

	task automatic test_end(input string nm);
		$display("test %s finished", nm);
	endtask : test_end

	task automatic test_done();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : test_done

	// ********************************************************
	// tests
	// ********************************************************
	logic [7:0] cf [4] = '{8'h71, 8'h62, 8'h75, 8'h73};
	initial begin
		logic [15:0] ev;
		{arst_n, avs_read, avs_write, wdt_reset_req, wdt_irq_req} = '0;
		{avs_address, avs_writedata, periph_irq, cyc} = '0;
		{err_total, num_checks} = '0;
		avs_byteenable = 4'hf;
		rst_pin_n = 1'b1;
		repeat (8) @(posedge ref_clk);
		arst_n <= 1'b1;
		wait_rst();
		rd(ADDR_CTRL, 32'h34);
		rd(ADDR_SYSCTL, 32'h4);
		rd(ADDR_ENABLE, 32'h0);
		rd(ADDR_PENDING, 32'h0);
		rd(5'h14, 32'h0);
		test_end("reset values");
		wr(ADDR_ENABLE, 32'h000ffff0);
		wr(ADDR_CTRL, 32'h35);
		irq(16'h2003, 1'b0);
		rd(ADDR_PENDING, 32'h00020030);
		take(16'hfff4, 1'b1, 1'b0, 1'b0);
		chk("push_mie", 32'h1, {31'h0, cpu_out.push_mie});
		rd(ADDR_CTRL, 32'h34);
		rd(ADDR_PENDING, 32'h00020010);
		take(16'h0, 1'b0, 1'b0, 1'b0);
		u_cpu.ret(1'b1);
		rd(ADDR_CTRL, 32'h35);
		take(16'hffbc, 1'b1, 1'b0, 1'b0);
		wr(ADDR_CTRL, 32'h3d);
		take(16'hfff6, 1'b1, 1'b0, 1'b0);
		test_end("priority");
		for (int n = 4; n < 20; n++) begin
			ev = (n < 16) ? 16'hfff6 - 16'(2 * (n - 4)) :
				16'hffbe - 16'(2 * (n - 16));
			wr(ADDR_CTRL, 32'h3d);
			irq(16'h1 << (n - 4), 1'b0);
			take(ev, 1'b1, 1'b0, 1'b0);
		end
		irq(16'h0, 1'b1);
		take(16'hfff8, 1'b1, 1'b0, 1'b0);
		take(16'hfffc, 1'b1, 1'b1, 1'b0);
		take(16'hfffc, 1'b1, 1'b0, 1'b1);
		test_end("vectors");
		wr(ADDR_CTRL, 32'h30);
		u_cpu.fetch(16'h0010);
		rd(ADDR_PENDING, 32'h4);
		take(16'hfffa, 1'b1, 1'b0, 1'b0);
		u_cpu.fetch(16'h0100);
		rd(ADDR_PENDING, 32'h0);
		wr(ADDR_CTRL, 32'h32);
		u_cpu.fetch(16'h0100);
		rd(ADDR_PENDING, 32'h4);
		take(16'hfffa, 1'b1, 1'b0, 1'b0);
		test_end("trap interrupt");
		wr(ADDR_CTRL, 32'h34);
		u_cpu.fetch(16'h0fa0);
		wait_rst();
		rd(ADDR_STATUS, 32'hfffe0002);
		rd(ADDR_CTRL, 32'h34);
		wr(ADDR_STATUS, 32'hf);
		irq(16'h0002, 1'b0);
		@(posedge ref_clk);
		wdt_reset_req <= 1'b1;
		@(posedge ref_clk);
		wdt_reset_req <= 1'b0;
		wait_rst();
		rd(ADDR_STATUS, 32'hfffe0004);
		rd(ADDR_PENDING, 32'h0);
		wr(ADDR_STATUS, 32'hf);
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_SYSCTL, {28'h0, cf[i][7:4]});
			wr(ADDR_SYSCTL, {28'h0, cf[i][3:0]});
			wait_rst();
			rd(ADDR_STATUS, {16'hfffe, 12'h0, i < 3, 3'h0});
			rd(ADDR_SYSCTL, (i < 3) ? 32'h4 : 32'h3);
			wr(ADDR_STATUS, 32'hf);
		end
		test_end("malfunction resets");
		@(posedge ref_clk);
		rst_pin_n <= 1'b0;
		repeat (8) @(posedge ref_clk);
		rst_pin_n <= 1'b1;
		repeat (6) @(posedge ref_clk);
		chk("core_rst", 32'h0, {31'h0, cpu_out.core_rst});
		rst_pin_n <= 1'b0;
		repeat (20) @(posedge ref_clk);
		chk("core_rst", 32'h1, {31'h0, cpu_out.core_rst});
		rst_pin_n <= 1'b1;
		for (int i = 0; i < 10 && cpu_out.rst_release !== 1'b1; i++)
			@(negedge ref_clk);
		chk("rst_release", 32'h1, {31'h0, cpu_out.rst_release});
		chk("reset vector", 32'hfffe, {16'h0, cpu_out.vector});
		wait_rst();
		rd(ADDR_STATUS, 32'hfffe0001);
		test_end("pin reset");
		test_done();
	end
endmodule : testbench

`default_nettype wire
